// file: src/fault_routing_defines.vh
// offsets, field positions, reset values and timing counts of the fault routing block
`ifndef FAULT_ROUTING_DEFINES_VH
`define FAULT_ROUTING_DEFINES_VH
`define ADDR_LINREG_MASK      8'h87
`define ADDR_PIN_PRIMARY      8'h8a
`define ADDR_PIN_SECONDARY    8'h8b
`define ADDR_PIN_MISC         8'h8c
`define ADDR_RESET_ROUTE      8'h8d
`define ADDR_OPT_SHORT_WAIT   8'h7c
`define RST_LINREG_MASK       8'h07
`define RST_PIN_PRIMARY       8'h60
`define RST_PIN_SECONDARY     8'h00
`define RST_PIN_MISC          8'h00
`define RST_RESET_ROUTE       8'h00
`define LINREG_MASK_BITS      8'h07
`define RESET_ROUTE_BITS      8'h0f
`define SHORT_WAIT_BIT        3
`define CLK_HZ                20000000
`define RST_LONG_US           20000
`define RST_SHORT_US          1000
`define RST_LONG_CYCLES       ((`RST_LONG_US * (`CLK_HZ / 1000000)))
`define RST_SHORT_CYCLES      ((`RST_SHORT_US * (`CLK_HZ / 1000000)))
`endif

// file: src/reset_pulse_timer.v
// hold-low timer for the active-low reset output
`timescale 1ns/100ps
module reset_pulse_timer #(
	parameter [31:0] LONG_CYCLES  = 32'd400000,
	parameter [31:0] SHORT_CYCLES = 32'd20000
) (
	// clock and reset
	input  wire        sys_clk,
	input  wire        nrst,
	// control
	input  wire        trigger,
	input  wire        short_sel,
	// status
	output reg         active
);
	reg [31:0] count_reg;
	// a trigger while running restarts the count, so a repeating fault stretches the pulse
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			count_reg <= 32'h0;
			active    <= 1'b0;
		end else if (trigger) begin
			count_reg <= short_sel ? SHORT_CYCLES - 32'h1 : LONG_CYCLES - 32'h1;
			active    <= 1'b1;
		end else if (count_reg != 32'h0) begin
			count_reg <= count_reg - 32'h1;
		end else begin
			active    <= 1'b0;
		end
	end
endmodule // reset_pulse_timer

// file: src/fault_output_routing.v
// fault masking and routing onto the general-purpose pin and the reset output
// Summary of operation
// - mask bit 0 passes fault to hiccup/latch response; 1 gives no response.
// - linear regulator mask: overcurrent bit2, overvoltage bit1, undervoltage bit0, reset 1.
// - enabled fault pulls the general-purpose pin low; disabled fault leaves it.
// - primary pin register: overtemp bit7, primary buck faults bits 6..0, 6,5 reset 1.
// - secondary pin register: third buck bits 7..4, second buck bits 3..0.
// - misc pin register: bus crc, watchdog trio, config crc, linear regulator faults.
// - enabled reset-route fault drives reset low for the short-wait selected time.
// - reset route: sequencer bit3, watchdog restart/slow/fast bits 2..0, upper bits read zero.
// - watchdog restart fault raised at twice the too-slow window period without kick.
`timescale 1ns/100ps
`include "fault_routing_defines.vh"
module fault_output_routing #(
	parameter [31:0] RST_LONG_CYCLES  = `RST_LONG_CYCLES,
	parameter [31:0] RST_SHORT_CYCLES = `RST_SHORT_CYCLES
) (
	// clock and reset
	input  wire        sys_clk,
	input  wire        nrst,
	// register port
	input  wire [7:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_write,
	input  wire        reg_read,
	output reg  [7:0]  reg_rdata,
	// option bit from the option register at 0x7c
	input  wire        opt_short_fault_wait,
	// primary buck and temperature fault flags, bit order of the primary pin register
	input  wire [7:0]  primary_faults,
	// second and third buck fault flags, bit order of the secondary pin register
	input  wire [7:0]  secondary_faults,
	// misc fault flags: crc, watchdog fast/slow, config crc, linear regulator; sequencer fault for the reset route only
	input  wire        bus_crc_fault,
	input  wire        wdt_slow_fault,
	input  wire        wdt_fast_fault,
	input  wire        crc_recheck_fault,
	input  wire        seq_fault,
	input  wire [2:0]  linear_regulator_faults,
	// watchdog restart detection
	input  wire        wdt_slow_period_tick,
	input  wire        wdt_kick,
	// linear regulator response request toward the shutdown logic
	output reg  [2:0]  linreg_response_req,
	output reg         wdt_restart_fault,
	// general-purpose pin, open drain
	output reg         gpio_out,
	output reg         gpio_oe,
	// active-low reset output
	output reg         rst_out_n
);
	reg  [7:0] linreg_mask_reg;
	reg  [7:0] pin_primary_reg;
	reg  [7:0] pin_secondary_reg;
	reg  [7:0] pin_misc_reg;
	reg  [7:0] reset_route_reg;
	reg  [1:0] slow_periods_reg;
	reg  [3:0] reset_src_prev_reg;
	wire [7:0] misc_faults;
	wire [3:0] reset_src;
	wire [3:0] reset_rise;
	wire       pin_pull;
	wire       timer_active;
	wire       wr_linreg_mask;
	wire       wr_pin_primary;
	wire       wr_pin_secondary;
	wire       wr_pin_misc;
	wire       wr_reset_route;
	wire       pull_primary;
	wire       pull_secondary;
	wire       pull_misc;

	// read decode; unmapped addresses and reserved bits read zero
	function [7:0] pick;
		input [7:0] addr;
		input [7:0] a;
		input [7:0] b;
		input [7:0] c;
		input [7:0] d;
		input [7:0] e;
		begin
			case (addr)
				`ADDR_LINREG_MASK:   pick = a & `LINREG_MASK_BITS;
				`ADDR_PIN_PRIMARY:   pick = b;
				`ADDR_PIN_SECONDARY: pick = c;
				`ADDR_PIN_MISC:      pick = d;
				`ADDR_RESET_ROUTE:   pick = e & `RESET_ROUTE_BITS;
				default:             pick = 8'h00;
			endcase
		end
	endfunction

	// one write strobe per register; unmapped addresses strobe nothing
	assign wr_linreg_mask   = reg_write && (reg_addr == `ADDR_LINREG_MASK);
	assign wr_pin_primary   = reg_write && (reg_addr == `ADDR_PIN_PRIMARY);
	assign wr_pin_secondary = reg_write && (reg_addr == `ADDR_PIN_SECONDARY);
	assign wr_pin_misc      = reg_write && (reg_addr == `ADDR_PIN_MISC);
	assign wr_reset_route   = reg_write && (reg_addr == `ADDR_RESET_ROUTE);

	// reserved bits are never stored, and the read decode masks them to zero as well
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			linreg_mask_reg <= `RST_LINREG_MASK;
		else if (wr_linreg_mask)
			linreg_mask_reg <= reg_wdata & `LINREG_MASK_BITS;
	end

	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			pin_primary_reg <= `RST_PIN_PRIMARY;
		else if (wr_pin_primary)
			pin_primary_reg <= reg_wdata;
	end

	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			pin_secondary_reg <= `RST_PIN_SECONDARY;
		else if (wr_pin_secondary)
			pin_secondary_reg <= reg_wdata;
	end

	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			pin_misc_reg <= `RST_PIN_MISC;
		else if (wr_pin_misc)
			pin_misc_reg <= reg_wdata;
	end

	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			reset_route_reg <= `RST_RESET_ROUTE;
		else if (wr_reset_route)
			reset_route_reg <= reg_wdata & `RESET_ROUTE_BITS;
	end

	// read data is registered and holds until the next read
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			reg_rdata <= 8'h00;
		else if (reg_read)
			reg_rdata <= pick(reg_addr, linreg_mask_reg, pin_primary_reg, pin_secondary_reg,
				pin_misc_reg, reset_route_reg);
	end

	// restart fault: two slow periods with no kick; a kick wins over a tick
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			slow_periods_reg <= 2'h0;
		else if (wdt_kick)
			slow_periods_reg <= 2'h0;
		else if (wdt_slow_period_tick && slow_periods_reg != 2'h2)
			slow_periods_reg <= slow_periods_reg + 2'h1;
	end

	// the counter stops at two, so the flag stays up until the next kick
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			wdt_restart_fault <= 1'b0;
		else if (wdt_kick)
			wdt_restart_fault <= 1'b0;
		else if (wdt_slow_period_tick && slow_periods_reg == 2'h1)
			wdt_restart_fault <= 1'b1;
	end

	assign misc_faults = {bus_crc_fault, wdt_restart_fault, wdt_slow_fault, wdt_fast_fault,
		crc_recheck_fault, linear_regulator_faults};
	// level OR of every enabled flag; flags are expected already synchronous to sys_clk
	// per-register pull requests, kept apart so each group can be probed
	assign pull_primary   = |(primary_faults & pin_primary_reg);
	assign pull_secondary = |(secondary_faults & pin_secondary_reg);
	assign pull_misc      = |(misc_faults & pin_misc_reg);
	assign pin_pull       = pull_primary | pull_secondary | pull_misc;
	// sequencer and watchdog faults only; other faults never reach the reset output
	assign reset_src = {seq_fault, wdt_restart_fault, wdt_slow_fault, wdt_fast_fault} &
		reset_route_reg[3:0];
	// pulse starts on a newly enabled fault, so a held flag does not keep reset low forever
	assign reset_rise = reset_src & ~reset_src_prev_reg;

	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			reset_src_prev_reg <= 4'h0;
		else
			reset_src_prev_reg <= reset_src;
	end

	// request only; the hiccup or latch action itself lives in the shutdown logic
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			linreg_response_req <= 3'h0;
		else
			linreg_response_req <= linear_regulator_faults & ~linreg_mask_reg[2:0];
	end

	// open drain: data is tied low and only the enable moves
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			gpio_out <= 1'b0;
			gpio_oe  <= 1'b0;
		end else begin
			gpio_out <= 1'b0;
			gpio_oe  <= pin_pull;
		end
	end

	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			rst_out_n <= 1'b1;
		else
			rst_out_n <= ~timer_active;
	end

	// short or long hold is chosen when the pulse starts
	reset_pulse_timer #(
		.LONG_CYCLES  (RST_LONG_CYCLES),
		.SHORT_CYCLES (RST_SHORT_CYCLES)
	) u_timer (
		.sys_clk   (sys_clk),
		.nrst      (nrst),
		.trigger   (|reset_rise),
		.short_sel (opt_short_fault_wait),
		.active    (timer_active)
	);
endmodule // fault_output_routing

// file: verif/fault_output_routing_monitor.sv
// port assertions for the fault routing block
`timescale 1ns/100ps
module fault_output_routing_monitor #(
	parameter [31:0] RST_LONG_CYCLES  = 32'd20,
	parameter [31:0] RST_SHORT_CYCLES = 32'd5
) (
	input wire       sys_clk, nrst, reg_write, reg_read, opt_short_fault_wait,
	input wire [7:0] reg_addr, reg_wdata, reg_rdata, primary_faults, secondary_faults,
	input wire       bus_crc_fault, wdt_slow_fault, wdt_fast_fault, crc_recheck_fault, seq_fault,
	input wire [2:0] linear_regulator_faults, linreg_response_req,
	input wire       wdt_slow_period_tick, wdt_kick, wdt_restart_fault, gpio_out, gpio_oe, rst_out_n
);
	reg [31:0] low_cnt;
	wire any_src = |{primary_faults, secondary_faults, bus_crc_fault, wdt_slow_fault,
		wdt_fast_fault, crc_recheck_fault, wdt_restart_fault, linear_regulator_faults};
	// counts the reset pulse so its length is bounded without a long repetition
	always @(posedge sys_clk or negedge nrst)
		if (!nrst)
			low_cnt <= 32'd0;
		else
			low_cnt <= rst_out_n ? 32'd0 : low_cnt + 32'd1;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	AST_OPEN_DRAIN: assert property (gpio_out == 1'b0) else $error("pin data not low");
	AST_GPIO_CAUSE: assert property (gpio_oe |-> $past(any_src)) else $error("pin low, no fault");
	AST_LINREG_REQ: assert property ((linreg_response_req & ~$past(linear_regulator_faults)) == 3'h0)
		else $error("response without fault");
	AST_RST_WIDTH: assert property (low_cnt <= RST_LONG_CYCLES + 32'd2) else $error("reset too long");
	AST_RESTART_CLR: assert property (wdt_kick |=> !wdt_restart_fault) else $error("kick ignored");
	AST_RESTART_SET: assert property ($rose(wdt_restart_fault) |-> $past(wdt_slow_period_tick) &&
		!$past(wdt_kick)) else $error("restart without tick");
	AST_RDATA_HOLD: assert property (!$past(reg_read) |-> $stable(reg_rdata)) else $error("rdata moved");
	AST_MASK_RSVD: assert property ($past(reg_read) && $past(reg_addr) == 8'h87 |-> reg_rdata[7:3] == 5'h0)
		else $error("mask reserved set");
	AST_ROUTE_RSVD: assert property ($past(reg_read) && $past(reg_addr) == 8'h8d |-> reg_rdata[7:4] == 4'h0)
		else $error("route reserved set");
	cover property (low_cnt == RST_SHORT_CYCLES);
endmodule // fault_output_routing_monitor

// file: verif/host_pin_watch.sv
// host view of the open-drain pin and the reset output
`timescale 1ns/100ps
module host_pin_watch (
	input  wire gpio_out, gpio_oe, rst_out_n,
	output wire pin_level, host_in_reset
);
	// board pull-up brings the pin high once the device lets go
	assign pin_level = gpio_oe ? gpio_out : 1'b1;
	assign host_in_reset = !rst_out_n;
endmodule // host_pin_watch

// file: verif/test_fault_output_routing.sv
// self-checking bench for the fault routing block
`timescale 1ns/100ps
module test_fault_output_routing;
	localparam [31:0] LONG = 32'd20, SHORT = 32'd5;
	reg        sys_clk = 1'b0, nrst = 1'b0, wr_en = 1'b0, rd_en = 1'b0, short_sel = 1'b0, tick = 1'b0, kick = 1'b0;
	reg  [7:0] addr = 8'h00, wdata = 8'h00;
	reg [23:0] f = 24'h0;
	wire [7:0] rdata;
	wire [2:0] req;
	wire       restart, gpio_out, gpio_oe, rst_n, pin, host_rst;
	integer    fail_count = 0, comparisons = 0, i, a, n;
	fault_output_routing #(.RST_LONG_CYCLES(LONG), .RST_SHORT_CYCLES(SHORT)) DUT (.sys_clk(sys_clk),
		.nrst(nrst), .reg_addr(addr), .reg_wdata(wdata), .reg_write(wr_en), .reg_read(rd_en),
		.reg_rdata(rdata), .opt_short_fault_wait(short_sel), .primary_faults(f[7:0]),
		.secondary_faults(f[15:8]), .bus_crc_fault(f[23]), .wdt_slow_fault(f[21]),
		.wdt_fast_fault(f[20]), .crc_recheck_fault(f[19]), .seq_fault(f[22]),
		.linear_regulator_faults(f[18:16]), .wdt_slow_period_tick(tick), .wdt_kick(kick),
		.linreg_response_req(req), .wdt_restart_fault(restart), .gpio_out(gpio_out),
		.gpio_oe(gpio_oe), .rst_out_n(rst_n));
	host_pin_watch host (.gpio_out(gpio_out), .gpio_oe(gpio_oe), .rst_out_n(rst_n),
		.pin_level(pin), .host_in_reset(host_rst));
	initial begin
		forever #25 sys_clk = ~sys_clk;
	end
	task final_report;
		begin
			if (fail_count == 0 && comparisons > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	task chk(input [7:0] got, input [7:0] exp);
		begin
			comparisons = comparisons + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	// waits past the edge so outputs launched there have settled
	task cyc(input integer k);
		repeat (k) @(posedge sys_clk) #1;
	endtask
	task acc(input [7:0] ad, input [7:0] d, input w);
		begin
			@(posedge sys_clk);
			addr <= ad;
			wdata <= d;
			wr_en <= w;
			rd_en <= !w;
			@(posedge sys_clk);
			wr_en <= 1'b0;
			rd_en <= 1'b0;
			#1;
		end
	endtask
	task rd(input [7:0] ad, input [7:0] exp);
		begin
			acc(ad, 8'h00, 1'b0);
			chk(rdata, exp);
		end
	endtask
	task set(input [23:0] v);
		begin
			@(posedge sys_clk);
			f <= v;
			cyc(3);
		end
	endtask
	initial begin
		repeat (12) @(posedge sys_clk);
		nrst <= 1'b1;
		rd(8'h87, 8'h07);
		rd(8'h8a, 8'h60);
		rd(8'h8b, 8'h00);
		rd(8'h8c, 8'h00);
		rd(8'h8d, 8'h00);
		acc(8'h87, 8'hff, 1'b1);
		rd(8'h87, 8'h07);
		acc(8'h8d, 8'hff, 1'b1);
		rd(8'h8d, 8'h0f);
		acc(8'h8d, 8'h00, 1'b1);
		acc(8'h90, 8'hff, 1'b1);
		rd(8'h90, 8'h00);
		for (a = 0; a < 3; a = a + 1)
			for (i = 0; i < 8; i = i + 1)
				if (a != 2 || i != 6) begin
					acc(8'h8a + a[7:0], 8'h01 << i, 1'b1);
					set(24'h1 << (8 * a + i));
					chk({7'h0, pin}, 8'h00);
					set(~(24'h1 << (8 * a + i)));
					chk({7'h0, pin}, 8'h01);
					acc(8'h8a + a[7:0], 8'h00, 1'b1);
				end
		acc(8'h8c, 8'h01, 1'b1);
		set(24'h070000);
		chk({5'h0, req}, 8'h00);
		chk({7'h0, pin}, 8'h00);
		acc(8'h87, 8'h05, 1'b1);
		cyc(2);
		chk({5'h0, req}, 8'h02);
		acc(8'h87, 8'h00, 1'b1);
		cyc(2);
		chk({5'h0, req}, 8'h07);
		set(24'h0);
		for (i = 0; i < 4; i = i + 1) begin
			acc(8'h8d, 8'h01 << i, 1'b1);
			@(posedge sys_clk);
			short_sel <= i[0];
			tick <= (i == 2);
			f <= (i == 2) ? 24'h0 : 24'h1 << ((i == 3) ? 22 : 20 + i);
			n = 0;
			for (a = 1; a < 40; a = a + 1) begin
				@(posedge sys_clk);
				tick <= (i == 2) && (a == 2);
				#1;
				if (!rst_n)
					n = n + 1;
			end
			chk(n[7:0], i[0] ? SHORT[7:0] : LONG[7:0]);
			chk({7'h0, restart}, {7'h0, i == 2});
			@(posedge sys_clk);
			f <= 24'h0;
			kick <= 1'b1;
			@(posedge sys_clk);
			kick <= 1'b0;
		end
		acc(8'h8d, 8'h00, 1'b1);
		set(24'h400000);
		cyc(3);
		chk({7'h0, host_rst}, 8'h00);
		final_report;
	end
	initial begin
		#(6000 * 50);
		fail_count = fail_count + 1;
		final_report;
	end
endmodule // test_fault_output_routing
bind fault_output_routing fault_output_routing_monitor #(.RST_LONG_CYCLES(RST_LONG_CYCLES),
	.RST_SHORT_CYCLES(RST_SHORT_CYCLES)) mon (.sys_clk, .nrst, .reg_write, .reg_read,
	.opt_short_fault_wait, .reg_addr, .reg_wdata, .reg_rdata, .primary_faults, .secondary_faults,
	.bus_crc_fault, .wdt_slow_fault, .wdt_fast_fault, .crc_recheck_fault, .seq_fault,
	.linear_regulator_faults, .linreg_response_req, .wdt_slow_period_tick, .wdt_kick,
	.wdt_restart_fault, .gpio_out, .gpio_oe, .rst_out_n);
